// ### hw/fsr_pkg.sv
// shared constants for the security-register / suspend / power-down command block
package fsr_pkg;
  // opcodes handled locally
  localparam logic [7:0] OP_SET_WEL = 8'h06;
  localparam logic [7:0] OP_SEC_PROG = 8'h42;
  localparam logic [7:0] OP_SEC_READ = 8'h48;
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7A;
  localparam logic [7:0] OP_SLEEP = 8'hB9;
  localparam logic [7:0] OP_WAKE_ID = 8'hAB;
  localparam logic [7:0] OP_PARAM_RD = 8'h5A;
  // opcodes refused while a suspend is pending; the page programs only in a program suspend
  localparam logic [7:0] OP_WR_STATUS = 8'h01;
  localparam logic [7:0] OP_SEC_ERASE = 8'h44;
  localparam logic [7:0] OP_ER_SECT = 8'h20;
  localparam logic [7:0] OP_ER_32K = 8'h52;
  localparam logic [7:0] OP_ER_64K = 8'hD8;
  localparam logic [7:0] OP_ER_CHIP1 = 8'hC7;
  localparam logic [7:0] OP_ER_CHIP2 = 8'h60;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_QPAGE_PROG = 8'h32;
  // security register address fields
  localparam logic [3:0] SEL_FIRST = 4'h1;
  localparam logic [3:0] SEL_LAST = 4'h3;
  localparam logic [8:0] BYTE_LAST = 9'h1FF;
  localparam logic [8:0] BYTE_FIRST = 9'h000;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // byte positions within a frame
  localparam logic [3:0] IDX_OPCODE = 4'h0;
  localparam logic [3:0] IDX_ONE = 4'h1;
  localparam logic [3:0] IDX_ADDR_LAST = 4'h3;
  localparam logic [3:0] IDX_DUMMY = 4'h4;
  localparam logic [3:0] IDX_DATA_END = 4'h5;
  localparam logic [3:0] IDX_MAX = 4'hF;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // timing, 100 MHz system clock
  localparam int CLK_MHZ = 100;
  localparam int SLEEP_US = 3;
  localparam int WAKE_US = 20;
  localparam int RST_US = 30;
  localparam int PROG_US = 400;
  localparam int SLEEP_CYC = SLEEP_US * CLK_MHZ;
  localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
  localparam int RST_CYC = RST_US * CLK_MHZ;
  localparam int PROG_CYC = PROG_US * CLK_MHZ;
  localparam int CNT_W = 24;
  // background timer modes
  typedef enum logic [1:0] {
    FSR_IDLE = 2'b00,
    FSR_ENTER = 2'b01,
    FSR_WAKE = 2'b10,
    FSR_RECOVER = 2'b11
  } fsr_mode_e;
endpackage

// ### hw/fsr_buf.sv
// two-entry valid/ready buffer between byte fetch and serial shifter
`timescale 1ns/1ps
module fsr_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic flush_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1]; // entries
  logic [AW-1:0] wp, rp, next_wp, next_rp; // pointers
  logic [AW:0] cnt, next_cnt; // fill level
  logic push, pop;

  // handshakes and next pointers
  always_comb
  begin
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    next_wp = wp;
    next_rp = rp;
    next_cnt = cnt;
    if (flush_i)
    begin
      next_wp = '0;
      next_rp = '0;
      next_cnt = '0;
    end
    else
    begin
      if (push)
        next_wp = (wp == AW'(DEPTH - 1)) ? '0 : AW'(wp + 1'b1);
      if (pop)
        next_rp = (rp == AW'(DEPTH - 1)) ? '0 : AW'(rp + 1'b1);
      if (push && !pop)
        next_cnt = (AW + 1)'(cnt + 1'b1);
      else if (pop && !push)
        next_cnt = (AW + 1)'(cnt - 1'b1);
    end
  end

  assign in_ready_o = (cnt != (AW + 1)'(DEPTH)) && !flush_i;
  assign out_valid_o = (cnt != '0);
  assign out_data_o = mem[rp];

  // pointer registers
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end
    else
    begin
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
    end
  end

  // storage, no reset needed
  always_ff @(posedge sys_clk_i)
  begin
    if (push)
      mem[wp] <= in_data_i;
  end
endmodule

// ### hw/fsr_core.sv
// serial flash command logic: security registers, reset pair, suspend/resume, deep sleep
// Overview of operation
// - program needs latch, opcode, address, data
// - frame end starts timed program, latch cleared
// - locked security register ignores program
// - three registers, select in bits fifteen-twelve
// - read: opcode, address, dummy, data out
// - read address increments, wraps at last byte
// - accepted reset clears all volatile state
// - no command accepted during reset recovery
// - suspend accepted only during running array op
// - suspend sets flag, drops busy
// - program suspend refuses write/erase/program opcodes
// - erase suspend refuses status write, erases
// - resume clears flag, restores busy
// - sleep only on exactly eight bits
// - asleep only wake and reset accepted
// - sleep refused while busy
// - wake alone, commands only after interval
// - wake plus three dummies streams identifier
// - wake command ignored while busy
// - one lock bit per security register
`timescale 1ns/1ps
module fsr_core #(
  parameter int SLEEP_CYC = fsr_pkg::SLEEP_CYC,
  parameter int WAKE_CYC = fsr_pkg::WAKE_CYC,
  parameter int RST_CYC = fsr_pkg::RST_CYC,
  parameter int PROG_CYC = fsr_pkg::PROG_CYC,
  parameter logic [7:0] DEVICE_ID = 8'h3C // arbitrary identifier value
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // serial link pins
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_n_o,
  // status and lock bits
  input wire logic [2:0] secreg_lock_i,
  output logic write_in_progress_o,
  output logic write_enable_latch_o,
  output logic [1:0] suspend_flags_o,
  output logic deep_sleep_o,
  // main array engine
  input wire logic ext_busy_i,
  input wire logic ext_erase_i,
  output logic ext_suspend_o,
  output logic ext_cmd_valid_o,
  output logic [7:0] ext_cmd_op_o,
  output logic soft_reset_o,
  // parameter table
  output logic [8:0] param_addr_o,
  input wire logic [7:0] param_byte_i
);
  ////////////////////////////////////////////////////////////////
  // pin synchronisers, three flops and an agreement filter
  logic [2:0] cs_q, sck_q, si_q; // shift chains
  logic cs_f, sck_f, si_f, cs_d, sck_d; // filtered levels and delays
  logic next_cs_f, next_sck_f, next_si_f;

  // filtered level follows once second and third agree
  always_comb
  begin
    next_cs_f = (cs_q[1] == cs_q[2]) ? cs_q[2] : cs_f;
    next_sck_f = (sck_q[1] == sck_q[2]) ? sck_q[2] : sck_f;
    next_si_f = (si_q[1] == si_q[2]) ? si_q[2] : si_f;
  end

  // synchroniser registers
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      cs_q <= 3'h7;
      sck_q <= 3'h0;
      si_q <= 3'h0;
      cs_f <= 1'b1;
      sck_f <= 1'b0;
      si_f <= 1'b0;
      cs_d <= 1'b1;
      sck_d <= 1'b0;
    end
    else
    begin
      cs_q <= {cs_q[1:0], cs_n_i};
      sck_q <= {sck_q[1:0], sclk_i};
      si_q <= {si_q[1:0], si_i};
      cs_f <= next_cs_f;
      sck_f <= next_sck_f;
      si_f <= next_si_f;
      cs_d <= cs_f;
      sck_d <= sck_f;
    end
  end

  logic active, sck_rise, sck_fall, frame_end; // link events
  assign active = !cs_f;
  assign sck_rise = active && sck_f && !sck_d;
  assign sck_fall = active && !sck_f && sck_d;
  assign frame_end = cs_f && !cs_d;

  ////////////////////////////////////////////////////////////////
  // security register storage
  logic [7:0] mem [0:1535]; // three registers of 512 bytes
  logic mem_we; // program byte strobe
  logic [10:0] mem_idx; // register and byte index

  ////////////////////////////////////////////////////////////////
  // command state
  logic [2:0] bit_cnt, next_bit_cnt; // bit within byte
  logic [3:0] byte_cnt, next_byte_cnt; // saturating byte index
  logic [7:0] sh_in, next_sh_in; // input shifter
  logic [7:0] opcode, next_opcode; // current opcode
  logic [23:0] addr, next_addr; // received address
  logic [8:0] ptr, next_ptr; // running byte pointer
  logic frame_ok, next_frame_ok; // opcode accepted
  logic out_phase, next_out_phase; // device drives data
  logic write_enable_latch, next_wel; // write enable latch
  logic armed, next_armed; // reset enabled
  logic dpd, next_dpd; // deep sleep
  logic susp_prog, next_susp_prog; // program suspended
  logic susp_erase, next_susp_erase; // erase suspended
  fsr_pkg::fsr_mode_e mode, next_mode; // background timer use
  logic [fsr_pkg::CNT_W-1:0] mode_cnt, next_mode_cnt; // mode timer
  logic [fsr_pkg::CNT_W-1:0] prog_cnt, next_prog_cnt; // program timer
  logic [7:0] sh_out, next_sh_out; // output shifter
  logic [2:0] out_cnt, next_out_cnt; // bits left in shifter
  logic so, next_so; // output bit
  logic cmd_v, next_cmd_v; // forwarded opcode strobe
  logic rst_p, next_rst_p; // reset pulse
  // combinational helpers
  logic byte_done, exact8, write_in_progress, sleepy, sec_prog_busy;
  logic [7:0] new_byte;
  logic [23:0] cur_addr;
  logic addr_ok, wr_allow, local_op, refused;
  logic [1:0] sel_m1;
  // buffer wires
  logic push_valid, push_ready, pop_valid, pop_ready, flush;
  logic [7:0] push_data, pop_data;

  assign byte_done = sck_rise && (bit_cnt == fsr_pkg::BIT_LAST);
  assign new_byte = {sh_in[6:0], si_f};
  assign exact8 = (byte_cnt == fsr_pkg::IDX_ONE) && (bit_cnt == 3'h0);
  assign sec_prog_busy = (prog_cnt != '0);
  assign write_in_progress = sec_prog_busy || (ext_busy_i && !(susp_prog || susp_erase));
  assign sleepy = dpd || (mode == fsr_pkg::FSR_ENTER);
  assign cur_addr = addr;
  // valid address: high byte zero, select one to three, bits 11-9 zero
  assign addr_ok = (cur_addr[23:16] == 8'h00) && (cur_addr[11:9] == 3'h0)
    && (cur_addr[15:12] >= fsr_pkg::SEL_FIRST) && (cur_addr[15:12] <= fsr_pkg::SEL_LAST);
  assign sel_m1 = 2'(cur_addr[13:12] - 2'h1);
  assign mem_idx = {sel_m1, ptr};
  // program only with latch, idle, no program suspend, unlocked
  assign wr_allow = write_enable_latch && !write_in_progress && !susp_prog && addr_ok && !secreg_lock_i[sel_m1];
  assign mem_we = byte_done && frame_ok && (opcode == fsr_pkg::OP_SEC_PROG)
    && (byte_cnt >= fsr_pkg::IDX_DUMMY) && wr_allow;
  assign local_op = (new_byte == fsr_pkg::OP_SET_WEL) || (new_byte == fsr_pkg::OP_SEC_PROG)
    || (new_byte == fsr_pkg::OP_SEC_READ) || (new_byte == fsr_pkg::OP_RST_EN)
    || (new_byte == fsr_pkg::OP_RST) || (new_byte == fsr_pkg::OP_SUSPEND)
    || (new_byte == fsr_pkg::OP_RESUME) || (new_byte == fsr_pkg::OP_SLEEP)
    || (new_byte == fsr_pkg::OP_WAKE_ID) || (new_byte == fsr_pkg::OP_PARAM_RD);
  // opcodes the array engine must not see during a suspend
  assign refused = ((susp_prog || susp_erase) && ((new_byte == fsr_pkg::OP_WR_STATUS)
    || (new_byte == fsr_pkg::OP_SEC_ERASE) || (new_byte == fsr_pkg::OP_ER_SECT)
    || (new_byte == fsr_pkg::OP_ER_32K) || (new_byte == fsr_pkg::OP_ER_64K)
    || (new_byte == fsr_pkg::OP_ER_CHIP1) || (new_byte == fsr_pkg::OP_ER_CHIP2)))
    || (susp_prog && ((new_byte == fsr_pkg::OP_PAGE_PROG) || (new_byte == fsr_pkg::OP_QPAGE_PROG)));

  ////////////////////////////////////////////////////////////////
  // byte fetch into the buffer
  always_comb
  begin
    push_valid = out_phase && active;
    if (opcode == fsr_pkg::OP_WAKE_ID)
      push_data = DEVICE_ID;
    else if (opcode == fsr_pkg::OP_PARAM_RD)
      push_data = param_byte_i;
    else if (addr_ok)
      push_data = mem[mem_idx];
    else
      push_data = fsr_pkg::ERASED_BYTE;
  end
  assign flush = !active;
  assign pop_ready = sck_fall && out_phase && (out_cnt == 3'h0);

  fsr_buf #(.WIDTH(8), .DEPTH(2)) u_buf (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .flush_i(flush),
    .in_valid_i(push_valid),
    .in_ready_o(push_ready),
    .in_data_i(push_data),
    .out_valid_o(pop_valid),
    .out_ready_i(pop_ready),
    .out_data_o(pop_data)
  );

  ////////////////////////////////////////////////////////////////
  // next-state for the command interpreter
  always_comb
  begin
    next_bit_cnt = bit_cnt;
    next_byte_cnt = byte_cnt;
    next_sh_in = sh_in;
    next_opcode = opcode;
    next_addr = addr;
    next_ptr = ptr;
    next_frame_ok = frame_ok;
    next_out_phase = out_phase;
    next_wel = write_enable_latch;
    next_armed = armed;
    next_dpd = dpd;
    next_susp_prog = susp_prog;
    next_susp_erase = susp_erase;
    next_mode = mode;
    next_mode_cnt = mode_cnt;
    next_prog_cnt = sec_prog_busy ? fsr_pkg::CNT_W'(prog_cnt - 1'b1) : prog_cnt;
    next_sh_out = sh_out;
    next_out_cnt = out_cnt;
    next_so = so;
    next_cmd_v = 1'b0;
    next_rst_p = 1'b0;
    // background timer
    if (mode != fsr_pkg::FSR_IDLE)
    begin
      if (mode_cnt <= fsr_pkg::CNT_W'(1))
      begin
        next_mode = fsr_pkg::FSR_IDLE;
        next_mode_cnt = '0;
        if (mode == fsr_pkg::FSR_ENTER)
          next_dpd = 1'b1;
      end
      else
        next_mode_cnt = fsr_pkg::CNT_W'(mode_cnt - 1'b1);
    end
    // bit and byte capture on rising edges
    if (sck_rise)
    begin
      next_sh_in = new_byte;
      next_bit_cnt = 3'(bit_cnt + 1'b1);
    end
    if (byte_done)
    begin
      if (byte_cnt != fsr_pkg::IDX_MAX)
        next_byte_cnt = 4'(byte_cnt + 1'b1);
      if (byte_cnt == fsr_pkg::IDX_OPCODE)
      begin
        next_opcode = new_byte;
        // refuse everything while recovering or waking; asleep only wake and reset
        next_frame_ok = (mode != fsr_pkg::FSR_RECOVER) && (mode != fsr_pkg::FSR_WAKE)
          && (!sleepy || (new_byte == fsr_pkg::OP_WAKE_ID) || (new_byte == fsr_pkg::OP_RST_EN)
          || (new_byte == fsr_pkg::OP_RST))
          && !((new_byte == fsr_pkg::OP_WAKE_ID) && write_in_progress);
        next_cmd_v = (mode != fsr_pkg::FSR_RECOVER) && (mode != fsr_pkg::FSR_WAKE)
          && !sleepy && !local_op && !refused;
      end
      else if (byte_cnt <= fsr_pkg::IDX_ADDR_LAST)
      begin
        next_addr = {addr[15:0], new_byte};
        next_ptr = next_addr[8:0];
        // identifier stream starts after three dummies
        if ((byte_cnt == fsr_pkg::IDX_ADDR_LAST) && (opcode == fsr_pkg::OP_WAKE_ID))
          next_out_phase = frame_ok;
      end
      else if ((byte_cnt == fsr_pkg::IDX_DUMMY)
        && ((opcode == fsr_pkg::OP_SEC_READ) || (opcode == fsr_pkg::OP_PARAM_RD)))
        next_out_phase = frame_ok;
      // program pointer wraps within the page
      if (mem_we)
        next_ptr = {ptr[8], 8'(ptr[7:0] + 1'b1)};
    end
    // fetch pointer advances per fetched byte, wrapping at the register end
    if (push_valid && push_ready && (opcode != fsr_pkg::OP_WAKE_ID))
      next_ptr = (ptr == fsr_pkg::BYTE_LAST) ? fsr_pkg::BYTE_FIRST : 9'(ptr + 1'b1);
    // serial output on falling edges, MSB first
    if (pop_ready)
    begin
      next_so = pop_valid ? pop_data[7] : 1'b1;
      next_sh_out = pop_valid ? {pop_data[6:0], 1'b0} : 8'hFF;
      next_out_cnt = fsr_pkg::BIT_LAST;
    end
    else if (sck_fall && out_phase)
    begin
      next_so = sh_out[7];
      next_sh_out = {sh_out[6:0], 1'b0};
      next_out_cnt = 3'(out_cnt - 1'b1);
    end
    // frame end: execute the non-streaming commands
    if (frame_end)
    begin
      next_bit_cnt = 3'h0;
      next_byte_cnt = fsr_pkg::IDX_OPCODE;
      next_out_phase = 1'b0;
      next_out_cnt = 3'h0;
      next_so = 1'b0;
      next_frame_ok = 1'b0;
      next_armed = frame_ok && exact8 && (opcode == fsr_pkg::OP_RST_EN);
      if (frame_ok)
      begin
        if (exact8 && (opcode == fsr_pkg::OP_SET_WEL))
          next_wel = 1'b1;
        if ((opcode == fsr_pkg::OP_SEC_PROG) && (byte_cnt >= fsr_pkg::IDX_DATA_END)
          && (bit_cnt == 3'h0) && wr_allow)
        begin
          next_prog_cnt = fsr_pkg::CNT_W'(PROG_CYC);
          next_wel = 1'b0;
        end
        if (exact8 && (opcode == fsr_pkg::OP_SLEEP) && !write_in_progress && !sleepy)
        begin
          next_mode = fsr_pkg::FSR_ENTER;
          next_mode_cnt = fsr_pkg::CNT_W'(SLEEP_CYC);
        end
        if ((opcode == fsr_pkg::OP_WAKE_ID) && sleepy && (bit_cnt == 3'h0))
        begin
          next_dpd = 1'b0;
          next_mode = fsr_pkg::FSR_WAKE;
          next_mode_cnt = fsr_pkg::CNT_W'(WAKE_CYC);
        end
        if (exact8 && (opcode == fsr_pkg::OP_SUSPEND) && write_in_progress && ext_busy_i
          && !sec_prog_busy && !susp_prog && !susp_erase)
        begin
          next_susp_erase = ext_erase_i;
          next_susp_prog = !ext_erase_i;
        end
        if (exact8 && (opcode == fsr_pkg::OP_RESUME) && (susp_prog || susp_erase) && !write_in_progress)
        begin
          next_susp_prog = 1'b0;
          next_susp_erase = 1'b0;
        end
        if (exact8 && (opcode == fsr_pkg::OP_RST) && armed)
        begin
          next_rst_p = 1'b1;
          next_wel = 1'b0;
          next_dpd = 1'b0;
          next_susp_prog = 1'b0;
          next_susp_erase = 1'b0;
          next_prog_cnt = '0;
          next_mode = fsr_pkg::FSR_RECOVER;
          next_mode_cnt = fsr_pkg::CNT_W'(RST_CYC);
        end
      end
    end
  end

  // command interpreter registers
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      bit_cnt <= 3'h0;
      byte_cnt <= 4'h0;
      sh_in <= 8'h00;
      opcode <= 8'h00;
      addr <= 24'h000000;
      ptr <= 9'h000;
      frame_ok <= 1'b0;
      out_phase <= 1'b0;
      write_enable_latch <= 1'b0;
      armed <= 1'b0;
      dpd <= 1'b0;
      susp_prog <= 1'b0;
      susp_erase <= 1'b0;
      mode <= fsr_pkg::FSR_IDLE;
      mode_cnt <= '0;
      prog_cnt <= '0;
      sh_out <= 8'h00;
      out_cnt <= 3'h0;
      so <= 1'b0;
      cmd_v <= 1'b0;
      rst_p <= 1'b0;
    end
    else
    begin
      bit_cnt <= next_bit_cnt;
      byte_cnt <= next_byte_cnt;
      sh_in <= next_sh_in;
      opcode <= next_opcode;
      addr <= next_addr;
      ptr <= next_ptr;
      frame_ok <= next_frame_ok;
      out_phase <= next_out_phase;
      write_enable_latch <= next_wel;
      armed <= next_armed;
      dpd <= next_dpd;
      susp_prog <= next_susp_prog;
      susp_erase <= next_susp_erase;
      mode <= next_mode;
      mode_cnt <= next_mode_cnt;
      prog_cnt <= next_prog_cnt;
      sh_out <= next_sh_out;
      out_cnt <= next_out_cnt;
      so <= next_so;
      cmd_v <= next_cmd_v;
      rst_p <= next_rst_p;
    end
  end

  // security register writes, nonvolatile so never reset
  always_ff @(posedge sys_clk_i)
  begin
    if (mem_we)
      mem[mem_idx] <= new_byte;
  end

  // outputs
  assign so_o = so;
  assign so_oe_n_o = !(out_phase && active);
  assign write_in_progress_o = write_in_progress;
  assign write_enable_latch_o = write_enable_latch;
  assign suspend_flags_o = {susp_erase, susp_prog};
  assign deep_sleep_o = dpd;
  assign ext_suspend_o = susp_prog || susp_erase;
  assign ext_cmd_valid_o = cmd_v;
  assign ext_cmd_op_o = opcode;
  assign soft_reset_o = rst_p;
  assign param_addr_o = ptr;

  ////////////////////////////////////////////////////////////////
  // checks
  property p_prog_start;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    $rose(sec_prog_busy) |-> write_in_progress && !write_enable_latch;
  endproperty
  a_prog_start: assert property (p_prog_start) else $error("program start without busy or latch clear");
  property p_lock;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    mem_we |-> !secreg_lock_i[sel_m1] && write_enable_latch;
  endproperty
  a_lock: assert property (p_lock) else $error("write to locked register");
  property p_wrap;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (push_valid && push_ready && (opcode == fsr_pkg::OP_SEC_READ) && (ptr == fsr_pkg::BYTE_LAST))
      |=> (ptr == fsr_pkg::BYTE_FIRST);
  endproperty
  a_wrap: assert property (p_wrap) else $error("read pointer did not wrap");
  property p_reset;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    rst_p |-> !dpd && !write_enable_latch && !susp_prog && !susp_erase && (mode == fsr_pkg::FSR_RECOVER);
  endproperty
  a_reset: assert property (p_reset) else $error("reset left state behind");
  property p_recover;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (mode == fsr_pkg::FSR_RECOVER) |-> !cmd_v && !next_frame_ok;
  endproperty
  a_recover: assert property (p_recover) else $error("command taken during recovery");
  property p_suspend;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    $rose(susp_prog || susp_erase) |-> !write_in_progress && $past(write_in_progress) && ext_suspend_o;
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspend without running op");
  property p_resume;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    $fell(ext_suspend_o) && !rst_p |-> $past(!write_in_progress) && (write_in_progress == ext_busy_i);
  endproperty
  a_resume: assert property (p_resume) else $error("resume while busy");
  property p_sleep_busy;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (mode == fsr_pkg::FSR_ENTER) && $changed(mode) |-> $past(!write_in_progress);
  endproperty
  a_sleep_busy: assert property (p_sleep_busy) else $error("sleep entered while busy");
  property p_asleep;
    @(posedge sys_clk_i) disable iff (!nrst_i)
    $past(sleepy) && $past(mode) != fsr_pkg::FSR_ENTER |-> !cmd_v;
  endproperty
  a_asleep: assert property (p_asleep) else $error("opcode forwarded while asleep");
endmodule

// ### testbench/fsr_host.sv
// spi host model for the serial link
`timescale 1ns/1ps
module fsr_host (
  // link pins
  output logic cs_n_o,
  output logic sclk_o,
  output logic si_o,
  input wire logic so_i
);
  logic [7:0] rx; // last byte read
  event got; // byte captured
  // idle: deselected, clock low
  initial
  begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    si_o = 1'b0;
  end
  // n bits msb first, 80 ns period, sample late in high phase
  task automatic xb(input logic [7:0] d, input int n = 8, input bit cap = 0);
    for (int i = 7; i > 7 - n; i--)
    begin
      si_o = d[(i + 8) % 8];
      #40 sclk_o = 1'b1;
      #39 rx[(i + 8) % 8] = so_i;
      #1 sclk_o = 1'b0;
    end
    if (cap)
      -> got;
  endtask
  task automatic open_f;
    cs_n_o = 1'b0;
    #40;
  endtask
  // release; si flips so no stale level lingers
  task automatic close_f;
    #40 cs_n_o = 1'b1;
    si_o = ~si_o;
    #200;
  endtask
endmodule

// ### testbench/fsr_core_bench.sv
// self-checking bench for the serial flash command block
`timescale 1ns/1ps
`define CHK(n, e, v) begin checked++; if ((v) !== (e)) begin bad_count++; $display("[ERR] %s exp %h got %h", n, e, v); end end
module fsr_core_bench;
  localparam logic [7:0] ID = 8'hA5; // arbitrary identifier value
  logic sys_clk, nrst, busy, erase, so, so_oe_n, write_in_progress, write_enable_latch, sleep, esus, evld, srst, cs_n, sclk, si;
  logic [2:0] lock; // lock bits
  logic [1:0] sus; // suspend flags
  logic [7:0] op, d0, d1, e8;
  logic [8:0] paddr; // table pointer
  logic [7:0] exp_q[$]; // expected read bytes
  logic [7:0] ops[9] = '{8'h01, 8'h44, 8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60, 8'h02, 8'h32};
  int checked = 0, bad_count = 0, fwd = 0, rsts = 0;
  fsr_core #(.SLEEP_CYC(20), .WAKE_CYC(200), .RST_CYC(200), .PROG_CYC(50), .DEVICE_ID(ID)) u_fsr_core (
    .sys_clk_i(sys_clk), .nrst_i(nrst), .cs_n_i(cs_n), .sclk_i(sclk), .si_i(si), .so_o(so), .so_oe_n_o(so_oe_n),
    .secreg_lock_i(lock), .write_in_progress_o(write_in_progress), .write_enable_latch_o(write_enable_latch), .suspend_flags_o(sus),
    .deep_sleep_o(sleep), .ext_busy_i(busy), .ext_erase_i(erase), .ext_suspend_o(esus), .ext_cmd_valid_o(evld),
    .ext_cmd_op_o(op), .soft_reset_o(srst), .param_addr_o(paddr), .param_byte_i(paddr[7:0] ^ 8'h5C));
  // released line pulled high, so only a driven bit reaches the host
  fsr_host u_fsr_host (.cs_n_o(cs_n), .sclk_o(sclk), .si_o(si), .so_i(so_oe_n ? 1'b1 : so));
  // 100 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // pulse counters
  always @(posedge sys_clk) if (evld === 1'b1) fwd++;
  always @(posedge sys_clk) if (srst === 1'b1) rsts++;
  // read byte monitor
  always @(u_fsr_host.got)
    if (exp_q.size() > 0)
    begin
      e8 = exp_q.pop_front();
      `CHK("so byte", e8, u_fsr_host.rx)
    end
  task automatic drv(input logic b, input logic e, input logic [2:0] l);
    @(posedge sys_clk) #1;
    busy = b;
    erase = e;
    lock = l;
  endtask
  task automatic cmd(input logic [7:0] c, input int n = 8);
    u_fsr_host.open_f();
    u_fsr_host.xb(c, n);
    u_fsr_host.close_f();
  endtask
  // opcode and three address bytes, frame left open
  task automatic hdr(input logic [7:0] c, input logic [23:0] a);
    u_fsr_host.open_f();
    u_fsr_host.xb(c);
    for (int i = 2; i >= 0; i--) u_fsr_host.xb(a[i*8 +: 8]);
  endtask
  // optional dummy, then two expected bytes
  task automatic rd(input bit dm, input logic [7:0] x0, input logic [7:0] x1);
    if (dm)
      u_fsr_host.xb(8'h00);
    exp_q.push_back(x0);
    exp_q.push_back(x1);
    u_fsr_host.xb(8'h00, 8, 1);
    u_fsr_host.xb(8'h00, 8, 1);
    u_fsr_host.close_f();
  endtask
  task automatic prog(input logic [23:0] a, input logic [7:0] d);
    cmd(8'h06);
    hdr(8'h42, a);
    u_fsr_host.xb(d);
    u_fsr_host.close_f();
  endtask
  task automatic wrap_up;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #200us;
    bad_count++;
    wrap_up();
  end
  // main sequence
  initial
  begin
    {nrst, busy, erase, lock} = 6'h00;
    d0 = 8'($urandom(32'hF6F7));
    d1 = 8'($urandom());
    repeat (16) @(posedge sys_clk);
    #1 nrst = 1'b1;
    // stay off the sampling edge from here on
    repeat (4) @(posedge sys_clk);
    #1;
    `CHK("idle flags", 5'h00, {write_in_progress, write_enable_latch, sus, sleep})
    hdr(8'hAB, 24'h000000);
    rd(0, ID, ID);
    prog(24'h0011FF, d0);
    `CHK("prog start", 2'b10, {write_in_progress, write_enable_latch})
    #800;
    prog(24'h001000, d1);
    #800;
    `CHK("prog end", 1'b0, write_in_progress)
    hdr(8'h48, 24'h0011FF);
    rd(1, d0, d1);
    drv(0, 0, 3'b010);
    prog(24'h002000, d0);
    `CHK("locked", 1'b0, write_in_progress)
    $display("test secreg done");
    drv(1, 0, 3'b010);
    cmd(8'h75);
    `CHK("prog susp", 4'h3, {write_in_progress, sus, esus})
    foreach (ops[i]) cmd(ops[i]);
    prog(24'h001005, d0);
    `CHK("refused", 5'h00, {write_in_progress, fwd[3:0]})
    cmd(8'h03);
    cmd(8'h7A);
    `CHK("resume", 4'h8, {write_in_progress, sus, esus})
    drv(1, 1, 3'b010);
    cmd(8'h75);
    cmd(8'h02);
    cmd(8'h20);
    `CHK("erase susp", 7'h2A, {write_in_progress, sus, esus, fwd[2:0]})
    $display("test suspend done");
    drv(0, 0, 3'b000);
    cmd(8'h66);
    cmd(8'h99);
    cmd(8'h06);
    `CHK("soft reset", 5'h01, {sus, esus, write_enable_latch, rsts[1:0]})
    #2000;
    cmd(8'h06);
    `CHK("after recovery", 1'b1, write_enable_latch)
    $display("test reset done");
    drv(1, 0, 3'b000);
    cmd(8'hB9);
    #300;
    `CHK("sleep busy", 1'b0, sleep)
    drv(0, 0, 3'b000);
    cmd(8'hB9, 9);
    #300;
    `CHK("sleep 9 bits", 1'b0, sleep)
    cmd(8'hB9);
    #300;
    cmd(8'h03);
    `CHK("asleep", 4'hA, {sleep, fwd[2:0]})
    cmd(8'hAB);
    cmd(8'h03);
    #2000;
    cmd(8'h03);
    // forwarded opcode shows on the engine port too
    `CHK("woken", 12'h303, {sleep, fwd[2:0], op})
    $display("test sleep done");
    drv(1, 0, 3'b000);
    hdr(8'hAB, 24'h000000);
    // ignored wake leaves the line released
    rd(0, 8'hFF, 8'hFF);
    drv(0, 0, 3'b000);
    hdr(8'h5A, 24'h0000FF);
    rd(1, 8'hA3, 8'h5C);
    $display("test id and table done");
    #500;
    wrap_up();
  end
endmodule
